/* rio_remote_io.sv */
// Purpose: Remote start and stop, rack and vial capture, relay drive
// Assumes: Inputs synchronous to i_clk except the contact lines
// Notes: Polarity switch is read once after reset release
`timescale 1ns/1ps
`default_nettype none
module rio_remote_io #(
	parameter int unsigned DB_CYC = rio_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Contact inputs, low while shorted to the contact common, and the panel start, high to start
	input wire logic i_start_contact_n,
	input wire logic i_stop_contact_n,
	input wire logic i_panel_start,
	// Device status and configuration
	input wire logic i_init_done,
	input wire logic i_ready_pol_sw,
	input wire logic i_legacy_host,
	input wire logic i_relay_module,
	// Rack and vial data lines
	input wire logic [13:0] i_rack_vial_a,
	input wire logic [13:0] i_rack_vial_b,
	// Relay timed events from the host method
	input wire logic [6:0] i_primary_event,
	input wire logic [6:0] i_mirror_event,
	// Run status
	output logic o_sampling,
	output logic o_start_pulse,
	output logic o_stop_pulse,
	// Captured rack and vial data
	output logic [13:0] o_rack_vial_a,
	output logic [13:0] o_rack_vial_b,
	output logic [7:0] o_vial_a,
	output logic [5:0] o_rack_a,
	// Relay drives, high closes the contact
	output logic [6:0] o_primary_relay_bank,
	output logic [6:0] o_mirror_relay_bank,
	output logic o_aux_relay,
	output logic o_second_ready_relay,
	output logic o_ready_relay
);
	// ***************************************************************
	// Contact filtering
	// ***************************************************************
	rio_contact_if start_c();
	rio_contact_if stop_c();
	assign start_c.raw_n = i_start_contact_n;
	assign stop_c.raw_n = i_stop_contact_n;

	rio_debounce #(.DB_CYC(DB_CYC)) u_start_db (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.c(start_c)
	);
	rio_debounce #(.DB_CYC(DB_CYC)) u_stop_db (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.c(stop_c)
	);

	// ***************************************************************
	// Run control
	// ***************************************************************
	rio_pkg::rio_run_t run_q, run_d;
	logic start_q, stop_q;
	logic pol_q, pol_taken_q;
	logic [13:0] rv_a_q, rv_b_q;
	logic [6:0] prim_q, mirr_q;
	logic aux_q, sec_rdy_q, rdy_q;

	// Start and stop decode
	wire sampling_w = (run_q == rio_pkg::RIO_SAMPLING);
	wire ready_w = i_init_done && !sampling_w && pol_taken_q;
	wire start_go = (start_c.press || i_panel_start) && ready_w;
	wire stop_go = stop_c.press && sampling_w;

	// Next run state
	always_comb
	begin
		run_d = run_q;
		case (run_q)
			rio_pkg::RIO_IDLE: if (start_go) run_d = rio_pkg::RIO_SAMPLING;
			rio_pkg::RIO_SAMPLING: if (stop_go) run_d = rio_pkg::RIO_IDLE;
			default: run_d = rio_pkg::RIO_IDLE;
		endcase
	end

	// Run state and action pulses
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			run_q <= rio_pkg::RIO_IDLE;
			start_q <= 1'b0;
			stop_q <= 1'b0;
		end
		else
		begin
			run_q <= run_d;
			start_q <= start_go;
			stop_q <= stop_go;
		end
	end

	// Polarity switch taken once after reset release
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			pol_q <= 1'b0;
			pol_taken_q <= 1'b0;
		end
		else if (!pol_taken_q)
		begin
			pol_q <= i_ready_pol_sw;
			pol_taken_q <= 1'b1;
		end
	end

	// ***************************************************************
	// Rack and vial capture
	// ***************************************************************
	// Port a taken at injection, port b only without a legacy host; bits kept exactly as presented
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rv_a_q <= rio_pkg::RV_RESET;
			rv_b_q <= rio_pkg::RV_RESET;
		end
		else if (start_go)
		begin
			rv_a_q <= i_rack_vial_a;
			if (!i_legacy_host)
			begin
				rv_b_q <= i_rack_vial_b;
			end
		end
	end

	// Field split of the first port; the host applies its own mask
	assign o_vial_a = rv_a_q[rio_pkg::VIAL_LSB +: rio_pkg::VIAL_W];
	assign o_rack_a = rv_a_q[rio_pkg::RACK_LSB +: rio_pkg::RACK_W];

	// ***************************************************************
	// Relays
	// ***************************************************************
	// Bank selection; an absent module leaves both banks open
	wire [6:0] prim_d = i_relay_module ? i_primary_event : rio_pkg::BANK_RESET;
	wire [6:0] mirr_src = i_legacy_host ? i_primary_event : i_mirror_event;
	wire [6:0] mirr_d = i_relay_module ? mirr_src : rio_pkg::BANK_RESET;

	// Relay registers
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			prim_q <= rio_pkg::BANK_RESET;
			mirr_q <= rio_pkg::BANK_RESET;
			aux_q <= 1'b0;
			sec_rdy_q <= 1'b0;
			rdy_q <= 1'b0;
		end
		else
		begin
			prim_q <= prim_d;
			mirr_q <= mirr_d;
			aux_q <= i_primary_event[rio_pkg::AUX_EVENT];
			sec_rdy_q <= prim_d[0];
			rdy_q <= ready_w ^ pol_q;
		end
	end

	// Output drive
	assign o_sampling = sampling_w;
	assign o_start_pulse = start_q;
	assign o_stop_pulse = stop_q;
	assign o_rack_vial_a = rv_a_q;
	assign o_rack_vial_b = rv_b_q;
	assign o_primary_relay_bank = prim_q;
	assign o_mirror_relay_bank = mirr_q;
	assign o_aux_relay = aux_q;
	assign o_second_ready_relay = sec_rdy_q;
	assign o_ready_relay = rdy_q;

	// ***************************************************************
	// Checks
	// ***************************************************************
	property p_start;
		@(posedge i_clk) disable iff (i_reset)
		start_go |=> o_sampling && o_start_pulse;
	endproperty
	a_start: assert property (p_start) else $error("start did not begin sampling");

	property p_stop;
		@(posedge i_clk) disable iff (i_reset)
		stop_go |=> !o_sampling && o_stop_pulse;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not end sampling");

	property p_capture;
		@(posedge i_clk) disable iff (i_reset)
		start_go |=> o_rack_vial_a == $past(i_rack_vial_a);
	endproperty
	a_capture: assert property (p_capture) else $error("rack vial not captured");

	property p_hold;
		@(posedge i_clk) disable iff (i_reset)
		!start_go |=> $stable(o_rack_vial_a) && $stable(o_rack_vial_b);
	endproperty
	a_hold: assert property (p_hold) else $error("rack vial changed without start");

	property p_legacy_port;
		@(posedge i_clk) disable iff (i_reset)
		(start_go && i_legacy_host) |=> $stable(o_rack_vial_b);
	endproperty
	a_legacy_port: assert property (p_legacy_port) else $error("second port used");

	property p_primary;
		@(posedge i_clk) disable iff (i_reset)
		i_relay_module |=> o_primary_relay_bank == $past(i_primary_event);
	endproperty
	a_primary: assert property (p_primary) else $error("primary bank wrong");

	property p_mirror;
		@(posedge i_clk) disable iff (i_reset)
		(i_relay_module && i_legacy_host) |=> o_mirror_relay_bank == o_primary_relay_bank;
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror bank not copying");

	property p_aux;
		@(posedge i_clk) disable iff (i_reset)
		##1 o_aux_relay == $past(i_primary_event[0]);
	endproperty
	a_aux: assert property (p_aux) else $error("aux relay wrong");

	property p_second_ready;
		@(posedge i_clk) disable iff (i_reset)
		i_relay_module |=> o_second_ready_relay == $past(i_primary_event[0]);
	endproperty
	a_second_ready: assert property (p_second_ready) else $error("second ready wrong");

	property p_ready_pol;
		@(posedge i_clk) disable iff (i_reset)
		pol_taken_q |=> o_ready_relay == ($past(ready_w) ^ pol_q);
	endproperty
	a_ready_pol: assert property (p_ready_pol) else $error("ready polarity wrong");

	property p_pol_once;
		@(posedge i_clk) disable iff (i_reset)
		pol_taken_q |=> $stable(pol_q);
	endproperty
	a_pol_once: assert property (p_pol_once) else $error("polarity reread");

	c_run: cover property (@(posedge i_clk) disable iff (i_reset) start_go ##[1:1000] stop_go);
	c_legacy: cover property (@(posedge i_clk) disable iff (i_reset) start_go && i_legacy_host);
	c_pol_on: cover property (@(posedge i_clk) disable iff (i_reset) pol_q && o_ready_relay);
endmodule
`default_nettype wire

/* rio_pkg.sv */
// Purpose: Shared constants and types of the remote I/O and relay block
// Assumes: 100 MHz system clock
// Notes: Field positions follow the rack and vial connector bit order
`default_nettype none
package rio_pkg;
	// ***************************************************************
	// Clock and timing
	// ***************************************************************
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned DEBOUNCE_MS = 5;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned DB_CNT_W = 20;

	// ***************************************************************
	// Rack and vial word layout
	// ***************************************************************
	localparam int unsigned RV_W = 14;
	localparam int unsigned VIAL_LSB = 0;
	localparam int unsigned VIAL_W = 8;
	localparam int unsigned RACK_LSB = 8;
	localparam int unsigned RACK_W = 6;
	localparam int unsigned DIGIT_W = 4;
	localparam int unsigned RACK_D2_W = 2;
	localparam logic [13:0] RV_RESET = 14'h0000;

	// ***************************************************************
	// Relays
	// ***************************************************************
	localparam int unsigned BANK_W = 7;
	localparam logic [6:0] BANK_RESET = 7'h00;
	localparam int unsigned AUX_EVENT = 0;

	// Run state of the acquisition
	typedef enum logic [0:0] {
		RIO_IDLE = 1'b0,
		RIO_SAMPLING = 1'b1
	} rio_run_t;
endpackage
`default_nettype wire

/* rio_contact_if.sv */
// Purpose: Carries one contact input and its clean closure pulse
// Assumes: Contact line is low while shorted to the contact common
// Notes: Used between the top block and its debounce filters
`timescale 1ns/1ps
`default_nettype none
interface rio_contact_if;
	logic raw_n;
	logic press;
	modport filt (input raw_n, output press);
	modport user (output raw_n, input press);
endinterface
`default_nettype wire

/* rio_debounce.sv */
// Purpose: Synchronise, debounce and edge-detect one contact closure
// Assumes: Closure pulls the line low
// Notes: One press pulse per settled closure
`timescale 1ns/1ps
`default_nettype none
module rio_debounce #(
	parameter int unsigned DB_CYC = rio_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Contact
	rio_contact_if.filt c
);
	logic sync1_q, sync2_q, stable_q, press_q;
	logic [rio_pkg::DB_CNT_W-1:0] cnt_q, cnt_d;
	wire settled = (cnt_q == rio_pkg::DB_CNT_W'(DB_CYC - 1));
	wire differs = (sync2_q != stable_q);

	// Count while the synchronised level differs from the accepted one
	assign cnt_d = (differs && !settled) ? cnt_q + 1'b1 : '0;

	// Synchroniser, settle counter and closure edge
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
			stable_q <= 1'b1;
			cnt_q <= '0;
			press_q <= 1'b0;
		end
		else
		begin
			sync1_q <= c.raw_n;
			sync2_q <= sync1_q;
			cnt_q <= cnt_d;
			if (differs && settled)
			begin
				stable_q <= sync2_q;
			end
			press_q <= differs && settled && !sync2_q; // Closure only
		end
	end

	assign c.press = press_q;

	// ***************************************************************
	// Checks
	// ***************************************************************
	property p_one_press;
		@(posedge i_clk) disable iff (i_reset)
		press_q |=> !press_q;
	endproperty
	a_one_press: assert property (p_one_press) else $error("press lasted two cycles");
endmodule
`default_nettype wire

/* rio_host_model.sv */
// Purpose: Far-side model of autosampler contacts, data lines and host events
// Assumes: Contacts idle open (high); a closure pulls the line low
// Notes: The bench calls the tasks just after a falling clock edge
`timescale 1ns/1ps
`default_nettype none
module rio_host_model (
	// Clock
	input wire logic i_clk,
	// Autosampler contacts and data lines
	output logic o_start_contact_n,
	output logic o_stop_contact_n,
	output logic [13:0] o_rack_vial_a,
	output logic [13:0] o_rack_vial_b,
	// Host method timed events
	output logic [6:0] o_primary_event,
	output logic [6:0] o_mirror_event
);
	// ***************************************************************
	// Idle state and drive tasks
	// ***************************************************************
	// Contacts open, lines and events quiet at time zero
	initial
	begin
		o_start_contact_n = 1'b1;
		o_stop_contact_n = 1'b1;
		o_rack_vial_a = 14'h0000;
		o_rack_vial_b = 14'h0000;
		o_primary_event = 7'h00;
		o_mirror_event = 7'h00;
	end

	// Close (low) or open (high) the start or stop contact
	task automatic contact(input logic stop, input logic level);
		if (stop)
			o_stop_contact_n = level;
		else
			o_start_contact_n = level;
	endtask

	// Present new rack and vial codes on both ports
	task automatic set_lines(input logic [13:0] a, input logic [13:0] b);
		o_rack_vial_a = a;
		o_rack_vial_b = b;
	endtask

	// Program the timed events of both banks
	task automatic set_events(input logic [6:0] p, input logic [6:0] m);
		o_primary_event = p;
		o_mirror_event = m;
	endtask

	// Host view of a captured word under its polarity and digit mask
	function automatic logic [13:0] host_read(input logic [13:0] w, input logic [13:0] mask,
		input logic neg_true);
		return (neg_true ? ~w : w) & mask;
	endfunction
endmodule
`default_nettype wire

/* rio_remote_io_tb_top.sv */
// Purpose: Self-checking bench of the remote I/O and relay block
// Assumes: Debounce shortened to 4 cycles
// Notes: Inputs change at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module rio_remote_io_tb_top;
	// ***************************************************************
	// Signals and instances
	// ***************************************************************
	logic i_clk, i_reset, i_panel_start, i_init_done, i_ready_pol_sw, i_legacy_host;
	logic i_relay_module, start_n, stop_n, o_sampling, o_start_pulse, o_stop_pulse;
	logic o_aux_relay, o_second_ready_relay, o_ready_relay;
	logic [13:0] rv_a, rv_b, o_rack_vial_a, o_rack_vial_b;
	logic [6:0] pev, mev, o_primary_relay_bank, o_mirror_relay_bank;
	logic [7:0] o_vial_a;
	logic [5:0] o_rack_a;
	int errors, num_checks, n_start, n_stop;

	rio_host_model rio_host_model_inst (.i_clk(i_clk), .o_start_contact_n(start_n),
		.o_stop_contact_n(stop_n), .o_rack_vial_a(rv_a), .o_rack_vial_b(rv_b),
		.o_primary_event(pev), .o_mirror_event(mev));

	rio_remote_io #(.DB_CYC(4)) rio_remote_io_inst (.i_clk(i_clk), .i_reset(i_reset),
		.i_start_contact_n(start_n), .i_stop_contact_n(stop_n), .i_panel_start(i_panel_start),
		.i_init_done(i_init_done), .i_ready_pol_sw(i_ready_pol_sw),
		.i_legacy_host(i_legacy_host), .i_relay_module(i_relay_module), .i_rack_vial_a(rv_a),
		.i_rack_vial_b(rv_b), .i_primary_event(pev), .i_mirror_event(mev),
		.o_sampling(o_sampling), .o_start_pulse(o_start_pulse), .o_stop_pulse(o_stop_pulse),
		.o_rack_vial_a(o_rack_vial_a), .o_rack_vial_b(o_rack_vial_b), .o_vial_a(o_vial_a),
		.o_rack_a(o_rack_a), .o_primary_relay_bank(o_primary_relay_bank),
		.o_mirror_relay_bank(o_mirror_relay_bank), .o_aux_relay(o_aux_relay),
		.o_second_ready_relay(o_second_ready_relay), .o_ready_relay(o_ready_relay));

	// 100 MHz clock
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Count start and stop actions
	always @(posedge i_clk)
	begin
		if (o_start_pulse === 1'b1)
			n_start++;
		if (o_stop_pulse === 1'b1)
			n_stop++;
	end

	// ***************************************************************
	// Compare, wait and report tasks
	// ***************************************************************
	task automatic check_bit(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask

	task automatic check_word(input string name, input logic [13:0] exp, input logic [13:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic stop_test;
		$display("Checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Wait a bounded time for the run state
	task automatic wait_samp(input logic exp);
		int n;
		n = 0;
		while (o_sampling !== exp && n < 40)
		begin
			@(negedge i_clk);
			n++;
		end
		if (o_sampling !== exp)
		begin
			errors++;
			$display("Error sampling wait expected %b seen %b", exp, o_sampling);
			stop_test();
		end
	endtask

	// Close a contact, hold it past the action, then open and let it settle
	task automatic closure(input logic stop, input logic exp);
		rio_host_model_inst.contact(stop, 1'b0);
		wait_samp(exp);
		repeat (20) @(negedge i_clk);
		rio_host_model_inst.contact(stop, 1'b1);
		repeat (10) @(negedge i_clk);
	endtask

	// Drive events and mode, then check both banks, the aux and second ready relays two cycles later
	task automatic relays(input logic md, input logic lg, input logic [6:0] pe, input logic [6:0] me);
		i_relay_module = md;
		i_legacy_host = lg;
		rio_host_model_inst.set_events(pe, me);
		repeat (2) @(negedge i_clk);
		check_word("primary bank", {7'h00, md ? pe : 7'h00}, {7'h00, o_primary_relay_bank});
		check_word("mirror bank", {7'h00, md ? (lg ? pe : me) : 7'h00},
			{7'h00, o_mirror_relay_bank});
		check_bit("aux relay", pe[0], o_aux_relay);
		check_bit("second ready", md & pe[0], o_second_ready_relay);
	endtask

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial
	begin
		{errors, num_checks, n_start, n_stop} = '0;
		{i_reset, i_relay_module} = 2'b11;
		{i_panel_start, i_init_done, i_ready_pol_sw, i_legacy_host} = 4'h0;
		repeat (16) @(negedge i_clk);
		i_reset = 1'b0;
		repeat (3) @(negedge i_clk);
		check_bit("ready relay", 1'b0, o_ready_relay);
		i_panel_start = 1'b1;
		@(negedge i_clk);
		i_panel_start = 1'b0;
		@(negedge i_clk);
		check_bit("sampling", 1'b0, o_sampling);
		i_init_done = 1'b1;
		i_ready_pol_sw = 1'b1;
		repeat (2) @(negedge i_clk);
		check_bit("ready relay", 1'b1, o_ready_relay);
		rio_host_model_inst.set_lines(14'h2A5C, 14'h1357);
		i_panel_start = 1'b1;
		@(negedge i_clk);
		i_panel_start = 1'b0;
		check_bit("start pulse", 1'b1, o_start_pulse);
		check_bit("sampling", 1'b1, o_sampling);
		check_word("port a", 14'h2A5C, o_rack_vial_a);
		check_word("port b", 14'h1357, o_rack_vial_b);
		check_word("vial", 14'h005C, {6'h00, o_vial_a});
		check_word("rack", 14'h002A, {8'h00, o_rack_a});
		check_word("host digit", 14'h0003,
			rio_host_model_inst.host_read(o_rack_vial_a, 14'h000F, 1'b1));
		rio_host_model_inst.set_lines(14'h3FFF, 14'h3FFF);
		i_panel_start = 1'b1;
		@(negedge i_clk);
		i_panel_start = 1'b0;
		repeat (2) @(negedge i_clk);
		check_word("port a held", 14'h2A5C, o_rack_vial_a);
		check_bit("ready relay", 1'b0, o_ready_relay);
		check_word("starts", 14'h0001, n_start[13:0]);
		closure(1'b1, 1'b0);
		check_word("stops", 14'h0001, n_stop[13:0]);
		i_legacy_host = 1'b1;
		rio_host_model_inst.set_lines(14'h0C21, 14'h0777);
		closure(1'b0, 1'b1);
		check_word("starts", 14'h0002, n_start[13:0]);
		check_word("port a", 14'h0C21, o_rack_vial_a);
		check_word("port b legacy", 14'h1357, o_rack_vial_b);
		closure(1'b1, 1'b0);
		check_word("stops", 14'h0002, n_stop[13:0]);
		for (int k = 0; k < 4; k++)
			relays(k[1], k[0], 7'h55 ^ k[6:0], 7'h2A);
		i_reset = 1'b1;
		i_init_done = 1'b0;
		repeat (2) @(negedge i_clk);
		i_reset = 1'b0;
		repeat (3) @(negedge i_clk);
		check_bit("ready relay", 1'b1, o_ready_relay);
		i_init_done = 1'b1;
		repeat (2) @(negedge i_clk);
		check_bit("ready relay", 1'b0, o_ready_relay);
		stop_test();
	end
endmodule
`default_nettype wire
